/* verilog/lls_pkg.sv */
// constants, register map and timing for the regulator and load-switch control block
// Summary of operation
// - target voltage is 0.8 V plus code*12.5 mV, or 0.6 V plus code*9.375 mV
// - reference-select bit is fixed at build time; host writes never change it
// - each regulator has a single output-voltage code register, no second setting
// - host turns each regulator on or off through its enable bit; device follows
// - a disabled regulator has its 50 ohm output discharge path switched on
// - power-good flag reads 0 while the output is below its threshold
// - unmasked undervoltage drives interrupt low until recovered or off and flag read
// - one threshold-select bit per regulator sets its current-limit threshold
// - at current limit on a masked channel, shutdown-disable bit picks turn-off or keep limiting
// - overcurrent status is latched until the host reads that register
// - unmasked limit undervoltage: all supplies off, interrupt, fault, restart after 100 ms
// - masked limit: still shut off or limit, no fault state, restart after 14 ms
// - two-bit slew field sets gate charging current, 2.5 uA to 10 uA
// - a disabled gate driver switches on its 75 ohm pulldown
// - switch power-good needs gate above input plus 1 V and drop under 100 mV
// - switch follows programmable on/off delays and sleep-state on/off settings
// - each enable or fault restart runs a fixed 275 us soft-start ramp
package lls_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_START_NS = 275000;
  localparam int SOFT_START_CYC = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASKED_RESTART_MS = 14;
  localparam int FAULT_RESTART_MS = 100;
  localparam int MASKED_RESTART_CYC = MASKED_RESTART_MS * (1000000 / CLK_PERIOD_NS);
  localparam int FAULT_RESTART_CYC = FAULT_RESTART_MS * (1000000 / CLK_PERIOD_NS);
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VCODE1 = 8'h04;
  localparam logic [7:0] ADDR_VCODE2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_OCSTAT = 8'h10;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h14;
  localparam logic [7:0] ADDR_IRQMASK = 8'h18;
  localparam logic [7:0] ADDR_LSDELAY = 8'h1c;
  localparam logic [7:0] ADDR_TARGET1 = 8'h20;
  localparam logic [7:0] ADDR_TARGET2 = 8'h24;
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_LSEN_POS = 2;
  localparam int CTRL_SLEW_POS = 3;
  localparam int CTRL_THR_POS = 5;
  localparam int CTRL_SDDIS_POS = 7;
  localparam int CTRL_UNMASK_POS = 9;
  localparam int CTRL_OCMASK_POS = 11;
  localparam int CTRL_LSSLP_POS = 13;
  localparam int CTRL_LSDSLP_POS = 14;
  localparam int CTRL_W = 15;
  localparam logic [14:0] CTRL_RST = 15'h0003;
  localparam logic [7:0] VCODE1_RST = 8'hc8;
  localparam logic [7:0] VCODE2_RST = 8'h50;
  localparam logic [31:0] LSDELAY_RST = 32'h0000_0000;
  localparam int IRQ_W = 5;
  localparam int IRQ_PG_POS = 0;
  localparam int IRQ_OC_POS = 2;
  localparam int IRQ_FLT_POS = 4;
  localparam logic [21:0] VBASE_REF0_UV = 22'h0c_3500;
  localparam logic [21:0] VSTEP_REF0_UV = 22'h00_30d4;
  localparam logic [21:0] VBASE_REF1_UV = 22'h09_27c0;
  localparam logic [21:0] VSTEP_REF1_UV = 22'h00_249f;
  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_RAMP = 4'b0010,
    CH_ON = 4'b0100,
    CH_HOLD = 4'b1000
  } lls_ch_type;
  typedef enum logic [1:0] {
    SYS_RUN = 2'b01,
    SYS_FAULT = 2'b10
  } lls_sys_type;
endpackage

/* verilog/lls_chan.sv */
// one regulator channel: enable, soft-start ramp and masked current-limit restart
`timescale 1ns/10ps
module lls_chan #(
  parameter int RESTART_CYC = lls_pkg::MASKED_RESTART_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  input wire logic at_limit,
  input wire logic shutdown_disable,
  input wire logic oc_masked,
  // drive
  output logic output_on,
  output logic discharge_en,
  output logic soft_start
);
  import lls_pkg::*;
  lls_ch_type state;
  lls_ch_type next_state;
  logic [19:0] cnt;
  wire trip = at_limit & oc_masked & ~shutdown_disable;
  wire ramp_done = cnt == 20'(SOFT_START_CYC - 1);
  wire hold_done = cnt == 20'(RESTART_CYC - 1);
  always_comb begin
    next_state = state;
    unique case (state)
      CH_OFF: if (enable) next_state = CH_RAMP;
      CH_RAMP: begin
        if (!enable) next_state = CH_OFF;
        else if (trip) next_state = CH_HOLD;
        else if (ramp_done) next_state = CH_ON;
      end
      CH_ON: begin
        if (!enable) next_state = CH_OFF;
        else if (trip) next_state = CH_HOLD;
      end
      CH_HOLD: begin
        if (!enable) next_state = CH_OFF;
        else if (hold_done) next_state = CH_RAMP;
      end
      default: next_state = CH_OFF;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CH_OFF;
      cnt <= 20'h0_0000;
      output_on <= 1'b0;
      discharge_en <= 1'b1;
      soft_start <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 20'h0_0000 : cnt + 20'h0_0001;
      output_on <= next_state == CH_RAMP || next_state == CH_ON;
      discharge_en <= !(next_state == CH_RAMP || next_state == CH_ON);
      soft_start <= next_state == CH_RAMP;
    end
  end
  a_ramp_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(soft_start) && enable && !trip |-> soft_start[*8])
    else $error("soft-start ramp ended early");
endmodule

/* verilog/lls_gate.sv */
// load-switch gate driver control with turn-on and turn-off delays and power-good
`timescale 1ns/10ps
module lls_gate (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic request,
  input wire logic [15:0] on_delay,
  input wire logic [15:0] off_delay,
  // comparators
  input wire logic gate_above_in,
  input wire logic drop_small,
  // drive
  output logic drive,
  output logic pulldown_on,
  output logic power_good
);
  import lls_pkg::*;
  logic [15:0] cnt;
  wire want_change = request != drive;
  wire delay_done = cnt >= (request ? on_delay : off_delay);
  wire next_drive = (want_change && delay_done) ? request : drive;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      drive <= 1'b0;
      pulldown_on <= 1'b1;
      power_good <= 1'b0;
    end else begin
      cnt <= (want_change && !delay_done) ? cnt + 16'h0001 : 16'h0000;
      drive <= next_drive;
      pulldown_on <= !next_drive;
      power_good <= next_drive & gate_above_in & drop_small;
    end
  end
  a_gate_pulldown: assert property (@(posedge pclk) disable iff (!presetn)
    pulldown_on == !drive)
    else $error("gate pulldown does not oppose drive");
endmodule

/* verilog/lls_top.sv */
// regulator and load-switch control with apb register file, fault restart and interrupts
`timescale 1ns/10ps
module lls_top #(
  parameter int MASKED_RESTART_CYC = lls_pkg::MASKED_RESTART_CYC,
  parameter int FAULT_RESTART_CYC = lls_pkg::FAULT_RESTART_CYC,
  parameter logic REF_SELECT = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // regulator comparators
  input wire logic [1:0] reg_below_pg,
  input wire logic [1:0] reg_at_limit,
  // load-switch comparators and sleep states
  input wire logic ls_gate_above_in,
  input wire logic ls_drop_small,
  input wire logic sleep_state,
  input wire logic deep_sleep_state,
  // regulator drive
  output logic [1:0] reg_enable,
  output logic [1:0] reg_discharge,
  output logic [1:0] reg_soft_start,
  output logic [7:0] reg1_voltage_code,
  output logic [7:0] reg2_voltage_code,
  output logic reg_ref_select,
  output logic reg1_overcurrent_threshold,
  output logic reg2_overcurrent_threshold,
  // load-switch drive
  output logic island_gate_drive,
  output logic gate_pulldown,
  output logic [1:0] gate_slew_select,
  output logic ls_power_good,
  // fault and interrupts
  output logic supply_fault_state,
  output logic interrupt_out_n,
  output logic irq
);
  import lls_pkg::*;
  logic [CTRL_W-1:0] ctrl;
  logic [31:0] ls_delay;
  logic [1:0] power_good_flag;
  logic [1:0] overcurrent_status_latch;
  logic [1:0] pg_pending;
  logic [1:0] below_q;
  logic [1:0] limit_q;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [21:0] target [2];
  logic [19:0] fault_cnt;
  lls_sys_type sys_state;
  lls_sys_type next_sys;

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_vc1 = paddr == ADDR_VCODE1;
  wire hit_vc2 = paddr == ADDR_VCODE2;
  wire hit_status = paddr == ADDR_STATUS;
  wire hit_ocstat = paddr == ADDR_OCSTAT;
  wire hit_istat = paddr == ADDR_IRQSTAT;
  wire hit_imask = paddr == ADDR_IRQMASK;
  wire hit_lsdly = paddr == ADDR_LSDELAY;
  wire hit_tgt1 = paddr == ADDR_TARGET1;
  wire hit_tgt2 = paddr == ADDR_TARGET2;
  wire mapped = hit_ctrl | hit_vc1 | hit_vc2 | hit_status | hit_ocstat | hit_istat | hit_imask | hit_lsdly
    | hit_tgt1 | hit_tgt2;
  wire status_read = rd & hit_status;
  wire ocstat_read = rd & hit_ocstat;

  // field views
  wire [1:0] host_en = ctrl[CTRL_EN_POS +: 2];
  wire [1:0] thr_sel = ctrl[CTRL_THR_POS +: 2];
  wire [1:0] sd_dis = ctrl[CTRL_SDDIS_POS +: 2];
  wire [1:0] unmask = ctrl[CTRL_UNMASK_POS +: 2];
  wire [1:0] oc_mask = ctrl[CTRL_OCMASK_POS +: 2];
  wire in_fault = sys_state == SYS_FAULT;
  wire [1:0] uv_trip = reg_at_limit & reg_below_pg & ~oc_mask & reg_enable;
  wire fault_done = fault_cnt == 20'(FAULT_RESTART_CYC - 1);

  wire [31:0] status_word = {23'h00_0000, reg_soft_start, supply_fault_state, reg_enable, REF_SELECT, ls_power_good,
    power_good_flag};
  wire [31:0] rd_mux =
    hit_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl} :
    hit_vc1 ? {24'h00_0000, reg1_voltage_code} :
    hit_vc2 ? {24'h00_0000, reg2_voltage_code} :
    hit_status ? status_word :
    hit_ocstat ? {30'h0000_0000, overcurrent_status_latch} :
    hit_istat ? {{(32 - IRQ_W){1'b0}}, irq_stat} :
    hit_imask ? {{(32 - IRQ_W){1'b0}}, irq_mask} :
    hit_lsdly ? ls_delay :
    hit_tgt1 ? {10'h000, target[0]} :
    hit_tgt2 ? {10'h000, target[1]} : 32'h0000_0000;

  // interrupt events
  wire [1:0] pg_drop = reg_below_pg & ~below_q & reg_enable;
  wire [1:0] oc_rise = reg_at_limit & ~limit_q;
  wire fault_entry = ~in_fault & (|uv_trip);
  wire [IRQ_W-1:0] irq_ev = {fault_entry, oc_rise, pg_drop};
  wire [IRQ_W-1:0] irq_clr = (wr & hit_istat) ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

  // load-switch request from enable, sleep settings and fault
  wire ls_sleep_ok = deep_sleep_state ? ctrl[CTRL_LSDSLP_POS] : sleep_state ? ctrl[CTRL_LSSLP_POS] : 1'b1;
  wire ls_request = ctrl[CTRL_LSEN_POS] & ls_sleep_ok & ~in_fault;

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  // writable registers; only the control register restores its default after fault restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      reg1_voltage_code <= VCODE1_RST;
      reg2_voltage_code <= VCODE2_RST;
      ls_delay <= LSDELAY_RST;
      irq_mask <= {IRQ_W{1'b0}};
    end else begin
      if (in_fault && fault_done) begin
        ctrl <= CTRL_RST;
      end else if (wr && hit_ctrl) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (wr && hit_vc1) begin
        reg1_voltage_code <= pwdata[7:0];
      end
      if (wr && hit_vc2) begin
        reg2_voltage_code <= pwdata[7:0];
      end
      if (wr && hit_lsdly) begin
        ls_delay <= pwdata;
      end
      if (wr && hit_imask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // system fault state
  always_comb begin
    next_sys = sys_state;
    unique case (sys_state)
      SYS_RUN: if (|uv_trip) next_sys = SYS_FAULT;
      SYS_FAULT: if (fault_done) next_sys = SYS_RUN;
      default: next_sys = SYS_RUN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_state <= SYS_RUN;
      fault_cnt <= 20'h0_0000;
      supply_fault_state <= 1'b0;
    end else begin
      sys_state <= next_sys;
      fault_cnt <= (next_sys == SYS_FAULT && in_fault) ? fault_cnt + 20'h0_0001 : 20'h0_0000;
      supply_fault_state <= next_sys == SYS_FAULT;
    end
  end

  // per-regulator status, latches and channel control
  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_ch
    wire [7:0] code = (ch == 0) ? reg1_voltage_code : reg2_voltage_code;
    wire [21:0] next_target = REF_SELECT ? VBASE_REF1_UV + code * VSTEP_REF1_UV : VBASE_REF0_UV + code * VSTEP_REF0_UV;
    wire recovered = ~reg_enable[ch] | ~reg_below_pg[ch];
    lls_chan #(
      .RESTART_CYC(MASKED_RESTART_CYC)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .enable(host_en[ch] & ~in_fault & ~(|uv_trip)),
      .at_limit(reg_at_limit[ch]),
      .shutdown_disable(sd_dis[ch]),
      .oc_masked(oc_mask[ch]),
      .output_on(reg_enable[ch]),
      .discharge_en(reg_discharge[ch]),
      .soft_start(reg_soft_start[ch])
    );
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        target[ch] <= 22'h00_0000;
        power_good_flag[ch] <= 1'b0;
        overcurrent_status_latch[ch] <= 1'b0;
        pg_pending[ch] <= 1'b0;
        below_q[ch] <= 1'b0;
        limit_q[ch] <= 1'b0;
      end else begin
        target[ch] <= next_target;
        power_good_flag[ch] <= reg_enable[ch] & ~reg_below_pg[ch];
        overcurrent_status_latch[ch] <= reg_at_limit[ch] | (overcurrent_status_latch[ch] & ~ocstat_read);
        pg_pending[ch] <= (unmask[ch] & reg_enable[ch] & reg_below_pg[ch])
          | (pg_pending[ch] & ~(recovered & status_read));
        below_q[ch] <= reg_below_pg[ch];
        limit_q[ch] <= reg_at_limit[ch];
      end
    end
  end

  // load-switch gate control
  lls_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .request(ls_request),
    .on_delay(ls_delay[15:0]),
    .off_delay(ls_delay[31:16]),
    .gate_above_in(ls_gate_above_in),
    .drop_small(ls_drop_small),
    .drive(island_gate_drive),
    .pulldown_on(gate_pulldown),
    .power_good(ls_power_good)
  );

  // interrupt status, mask and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {IRQ_W{1'b0}};
      irq <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      irq_stat <= irq_ev | (irq_stat & ~irq_clr);
      irq <= |(irq_stat & irq_mask);
      interrupt_out_n <= ~((|pg_pending) | in_fault);
    end
  end

  // static fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_ref_select <= 1'b0;
      reg1_overcurrent_threshold <= 1'b0;
      reg2_overcurrent_threshold <= 1'b0;
      gate_slew_select <= 2'h0;
    end else begin
      reg_ref_select <= REF_SELECT;
      reg1_overcurrent_threshold <= thr_sel[0];
      reg2_overcurrent_threshold <= thr_sel[1];
      gate_slew_select <= ctrl[CTRL_SLEW_POS +: 2];
    end
  end

  // checks
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 psel && penable |-> pready)
    else $error("apb access not answered in one cycle");
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_done and (pwrite && hit_ctrl && !in_fault) |=> ctrl == $past(pwdata[CTRL_W-1:0]))
    else $error("control write not stored");
  a_discharge_off: assert property (@(posedge pclk) disable iff (!presetn)
    reg_discharge == ~reg_enable)
    else $error("discharge not opposite to enable");
  a_pg_flag: assert property (@(posedge pclk) disable iff (!presetn)
    reg_below_pg[0] |=> !power_good_flag[0])
    else $error("power-good set while below threshold");
  a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
    unmask[0] && reg_enable[0] && reg_below_pg[0] |=> ##1 !interrupt_out_n)
    else $error("undervoltage interrupt not driven");
  a_oc_latch: assert property (@(posedge pclk) disable iff (!presetn)
    reg_at_limit[0] |=> overcurrent_status_latch[0])
    else $error("overcurrent not latched");
  a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(supply_fault_state) |-> reg_enable == 2'b00 ##1 !interrupt_out_n)
    else $error("supplies not off on fault");
  a_ref_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    s_done ##1 1'b1 |-> reg_ref_select == REF_SELECT)
    else $error("reference select changed");
  a_slew_follow: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ctrl) |=> gate_slew_select == $past(ctrl[CTRL_SLEW_POS +: 2]))
    else $error("slew select not applied");
endmodule

/* testbench/lls_plant.sv */
// analog side model: regulator comparators and the external gate
`timescale 1ns/10ps
module lls_plant (
  // clock
  input wire logic pclk,
  // stimulus from the bench
  input wire logic [1:0] uv,
  input wire logic [1:0] ovl,
  // device drive
  input wire logic [1:0] reg_enable,
  input wire logic drive,
  // comparator outputs
  output logic [1:0] below,
  output logic [1:0] limit,
  output logic gate_above,
  output logic drop_small
);
  logic [1:0] gate_hist = 2'b00;
  assign below = ~reg_enable | uv;
  assign limit = reg_enable & ovl;
  always @(posedge pclk) begin
    gate_hist <= {gate_hist[0], drive};
  end
  assign gate_above = gate_hist[0];
  assign drop_small = gate_hist[1] & gate_hist[0];
endmodule

/* testbench/testbench.sv */
// self-checking bench for the regulator and load-switch control block
`timescale 1ns/10ps
module testbench;
  import lls_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] uv = 2'b00;
  logic [1:0] ovl = 2'b00;
  logic sleep_state = 1'b0;
  logic deep_sleep = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, gabove, dsmall, ref_sel, thr1, thr2, drive, gate_pd, ls_pg, fault, int_n, irq;
  logic [1:0] below, limit, reg_enable, reg_discharge, reg_soft_start, slew;
  logic [7:0] code1, code2;
  int failures = 0;
  int comparisons = 0;
  int n;

  always #50 pclk = ~pclk;

  lls_top #(.MASKED_RESTART_CYC(50), .FAULT_RESTART_CYC(60), .REF_SELECT(1'b0)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_below_pg(below),
    .reg_at_limit(limit), .ls_gate_above_in(gabove), .ls_drop_small(dsmall), .sleep_state(sleep_state),
    .deep_sleep_state(deep_sleep), .reg_enable(reg_enable), .reg_discharge(reg_discharge),
    .reg_soft_start(reg_soft_start), .reg1_voltage_code(code1), .reg2_voltage_code(code2),
    .reg_ref_select(ref_sel), .reg1_overcurrent_threshold(thr1), .reg2_overcurrent_threshold(thr2),
    .island_gate_drive(drive), .gate_pulldown(gate_pd), .gate_slew_select(slew), .ls_power_good(ls_pg),
    .supply_fault_state(fault), .interrupt_out_n(int_n), .irq(irq));

  lls_plant i_plant (.pclk(pclk), .uv(uv), .ovl(ovl), .reg_enable(reg_enable), .drive(drive),
    .below(below), .limit(limit), .gate_above(gabove), .drop_small(dsmall));

  task close_out;
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task step(input int b);
    @(posedge pclk);
    #1;
    n++;
    if (n > b) begin
      failures++;
      $display("[FAIL] %0t wait limit", $time);
      close_out();
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        failures++;
        $display("[FAIL] %0t apb wait limit", $time);
        close_out();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task t_reset;
    n = 0;
    do step(5); while (reg_enable !== 2'b11);
    chk(32'(reg_soft_start), 32'h3, "ramp at start");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h3, "ctrl reset");
    apb(1'b0, ADDR_VCODE1, 32'h0);
    chk(rd, 32'hc8, "code1 reset");
    apb(1'b0, ADDR_VCODE2, 32'h0);
    chk(rd, 32'h50, "code2 reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'({er, rd != 0}), 32'h2, "unmapped");
    n = 0;
    do step(3000); while (reg_soft_start !== 2'b00);
    chk(32'(n > 2700), 32'h1, "ramp length");
  endtask

  task t_volt;
    apb(1'b1, ADDR_VCODE1, 32'h10);
    apb(1'b0, ADDR_TARGET1, 32'h0);
    chk(rd, 32'd800000 + 32'd16 * 32'd12500, "target1");
    apb(1'b1, ADDR_VCODE2, 32'hff);
    apb(1'b0, ADDR_TARGET2, 32'h0);
    chk(rd, 32'd800000 + 32'd255 * 32'd12500, "target2");
    chk(32'({code2, code1}), 32'hff10, "code ports");
    apb(1'b1, ADDR_STATUS, 32'h8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({rd[3], ref_sel}), 32'h0, "ref select");
  endtask

  task t_enable;
    apb(1'b1, ADDR_CTRL, 32'h2);
    n = 0;
    do step(5); while (reg_enable !== 2'b10);
    chk(32'(reg_discharge), 32'h1, "discharge");
    apb(1'b1, ADDR_CTRL, 32'h3);
    n = 0;
    do step(5); while (reg_enable !== 2'b11);
    chk(32'(reg_soft_start[0]), 32'h1, "ramp on enable");
    n = 0;
    do step(3000); while (reg_soft_start !== 2'b00);
    chk(32'(n > 2700), 32'h1, "ramp length");
  endtask

  task t_pg;
    apb(1'b1, ADDR_CTRL, 32'h203);
    @(posedge pclk);
    uv <= 2'b01;
    n = 0;
    do step(5); while (int_n !== 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h0, "pg flag low");
    @(posedge pclk);
    uv <= 2'b00;
    n = 0;
    repeat (5) step(9);
    chk(32'(int_n), 32'h0, "irq line held");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h1, "pg flag high");
    repeat (3) step(9);
    chk(32'(int_n), 32'h1, "irq line freed");
  endtask

  task t_masked;
    apb(1'b1, ADDR_IRQMASK, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h803);
    @(posedge pclk);
    ovl <= 2'b01;
    n = 0;
    do step(10); while (reg_enable[0] !== 1'b0);
    apb(1'b0, ADDR_OCSTAT, 32'h0);
    chk(32'({rd[0], irq}), 32'h3, "limit latched");
    @(posedge pclk);
    ovl <= 2'b00;
    n = 0;
    do step(200); while (reg_enable[0] !== 1'b1);
    chk(32'({n > 30, fault}), 32'h2, "masked restart");
    apb(1'b0, ADDR_OCSTAT, 32'h0);
    chk(rd, 32'h0, "latch cleared");
    apb(1'b1, ADDR_IRQSTAT, 32'h1f);
    apb(1'b1, ADDR_CTRL, 32'h83);
    chk(32'(irq), 32'h0, "irq cleared");
    @(posedge pclk);
    ovl <= 2'b01;
    n = 0;
    repeat (20) step(30);
    chk(32'({reg_enable[0], fault}), 32'h2, "keep limiting");
    @(posedge pclk);
    ovl <= 2'b00;
  endtask

  task t_fault;
    apb(1'b1, ADDR_IRQMASK, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h3);
    @(posedge pclk);
    uv <= 2'b01;
    ovl <= 2'b01;
    n = 0;
    do step(5); while (fault !== 1'b1);
    @(posedge pclk);
    uv <= 2'b00;
    ovl <= 2'b00;
    #1;
    chk(32'({reg_enable, int_n}), 32'h0, "all off");
    n = 0;
    do step(200); while (fault !== 1'b0);
    chk(32'({n > 40, irq}), 32'h3, "fault restart");
    n = 0;
    do step(5); while (reg_enable !== 2'b11);
    chk(32'(reg_soft_start), 32'h3, "ramp on restart");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h3, "defaults");
    apb(1'b1, ADDR_IRQSTAT, 32'h1f);
    apb(1'b1, ADDR_IRQMASK, 32'h0);
  endtask

  task t_fields;
    logic [31:0] v;
    for (int s = 0; s < 4; s++) begin
      v = 32'h3 | 32'(s << 3) | 32'((s & 1) << 5) | 32'((s >> 1) << 6);
      apb(1'b1, ADDR_CTRL, v);
      n = 0;
      step(5);
      chk(32'(slew), 32'(s), "slew code");
      chk(32'({thr2, thr1}), 32'(s), "thresholds");
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, v, "ctrl readback");
    end
  endtask

  task t_lsw;
    apb(1'b1, ADDR_LSDELAY, 32'h0005_0005);
    chk(32'(gate_pd), 32'h1, "pulldown idle");
    apb(1'b1, ADDR_CTRL, 32'h7);
    n = 0;
    step(9);
    chk(32'(drive), 32'h0, "on delay");
    do step(20); while (drive !== 1'b1);
    repeat (3) step(30);
    chk(32'({gate_pd, ls_pg}), 32'h1, "switch on");
    @(posedge pclk);
    sleep_state <= 1'b1;
    n = 0;
    do step(20); while (drive !== 1'b0);
    chk(32'({gate_pd, ls_pg}), 32'h2, "off in sleep");
    apb(1'b1, ADDR_CTRL, 32'h2007);
    n = 0;
    do step(20); while (drive !== 1'b1);
    chk(32'(gate_pd), 32'h0, "on in sleep");
    @(posedge pclk);
    deep_sleep <= 1'b1;
    n = 0;
    do step(20); while (drive !== 1'b0);
    chk(32'({gate_pd, ls_pg}), 32'h2, "off in deep sleep");
    apb(1'b1, ADDR_CTRL, 32'h6007);
    n = 0;
    do step(20); while (drive !== 1'b1);
    chk(32'(gate_pd), 32'h0, "on in deep sleep");
    @(posedge pclk);
    sleep_state <= 1'b0;
    deep_sleep <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_volt();
    t_enable();
    t_pg();
    t_masked();
    t_fault();
    t_fields();
    t_lsw();
    close_out();
  end
endmodule
